// ---- core/ksd_top.sv ----
// kernel segment decoder top: registered answer, axi4-lite registers, interrupt
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "ksd_consts.svh"
module ksd_top #(
  parameter int PA_W = 36
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // access request from the pipeline
  input wire logic req_valid_i,
  input wire logic [63:0] vaddr_i,
  input wire logic [7:0] space_identifier_i,
  input wire logic [1:0] privilege_mode_field_i,
  input wire logic exception_level_flag_i,
  input wire logic error_level_flag_i,
  input wire logic wide_kernel_addressing_i,
  // decode answer to translation buffer and cache
  output logic dec_valid_o,
  output ksd_pkg::ksd_seg_t seg_o,
  output logic mapped_o,
  output logic uncached_o,
  output logic [PA_W-1:0] paddr_o,
  output logic [7:0] key_space_o,
  output logic [63:0] key_vaddr_o,
  output logic reserved_o,
  output logic addr_err_o,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq_o
);

  // ===========================================================================
  // classifier
  logic kern_c;
  logic rsvd_fault_q;
  ksd_dec_if #(.PA_W(PA_W)) dif ();

  // kernel when mode field is 00 or either level flag is raised
  assign kern_c = (privilege_mode_field_i == `KSD_KMODE) | exception_level_flag_i |
                  error_level_flag_i;
  assign dif.vaddr = vaddr_i;
  assign dif.kernel = kern_c;
  assign dif.wide = wide_kernel_addressing_i;
  assign dif.error_level_flag = error_level_flag_i;
  assign dif.rsvd_fault = rsvd_fault_q;

  ksd_classify #(.PA_W(PA_W)) u_classify (
    .d(dif.dec)
  );

  // ===========================================================================
  // registered answer
  // one cycle of latency keeps every output straight from a flop
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dec_valid_o <= 1'b0;
      seg_o <= ksd_pkg::seg_none;
      mapped_o <= 1'b0;
      uncached_o <= 1'b0;
      paddr_o <= '0;
      key_space_o <= 8'h00;
      key_vaddr_o <= 64'h0;
      reserved_o <= 1'b0;
      addr_err_o <= 1'b0;
    end else begin
      dec_valid_o <= req_valid_i;
      seg_o <= dif.seg;
      mapped_o <= dif.mapped;
      uncached_o <= dif.uncached;
      paddr_o <= dif.paddr;
      // lookup key is unique per address space only on mapped windows
      key_space_o <= dif.mapped ? space_identifier_i : 8'h00;
      key_vaddr_o <= vaddr_i;
      reserved_o <= dif.reserved;
      addr_err_o <= req_valid_i & dif.addr_err;
    end
  end

  // ===========================================================================
  // control, status and mask registers
  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic [2:0] event_c;
  logic [2:0] clr_c;
  logic [63:0] err_vaddr_q;
  logic wr_go_c;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  assign wr_go_c = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign event_c = {3{req_valid_i}} & {dif.erl_user, dif.reserved, dif.addr_err};
  assign clr_c = (wr_go_c && awaddr_q == `KSD_OFS_STATUS && wstrb_q[0]) ?
                 wdata_q[2:0] : 3'h0;

  // sticky events; a new event beats a clear written in the same cycle
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      status_q <= 3'h0;
    end else begin
      status_q <= (status_q & ~clr_c) | event_c;
    end
  end

  // software controls: reserved-as-fault switch and interrupt mask
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rsvd_fault_q <= `KSD_CTRL_RST;
      mask_q <= `KSD_MASK_RST;
    end else if (wr_go_c && wstrb_q[0]) begin
      if (awaddr_q == `KSD_OFS_CTRL) begin
        rsvd_fault_q <= wdata_q[`KSD_CTRL_RSVD_FAULT];
      end
      if (awaddr_q == `KSD_OFS_MASK) begin
        mask_q <= wdata_q[2:0];
      end
    end
  end

  // last faulting address, so the handler need not replay the access
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      err_vaddr_q <= 64'h0;
    end else if (event_c[`KSD_ST_ADDR_ERR]) begin
      err_vaddr_q <= vaddr_i;
    end
  end

  // level interrupt while any unmasked status bit stands
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((status_q & ~clr_c) | event_c) & mask_q);
    end
  end

  // ===========================================================================
  // axi4-lite write channel
  // address and data are caught separately so either may come first
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `KSD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go_c) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == `KSD_OFS_CTRL || awaddr_q == `KSD_OFS_STATUS ||
                        awaddr_q == `KSD_OFS_MASK) ? `KSD_RESP_OKAY : `KSD_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ===========================================================================
  // axi4-lite read channel
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `KSD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `KSD_RESP_OKAY;
      unique case (s_axi_araddr)
        `KSD_OFS_CTRL: s_axi_rdata <= {31'h0, rsvd_fault_q};
        `KSD_OFS_STATUS: s_axi_rdata <= {29'h0, status_q};
        `KSD_OFS_MASK: s_axi_rdata <= {29'h0, mask_q};
        `KSD_OFS_ERR_LO: s_axi_rdata <= err_vaddr_q[31:0];
        `KSD_OFS_ERR_HI: s_axi_rdata <= err_vaddr_q[63:32];
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `KSD_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ===========================================================================
  // checks on the registered answer, the status bits and the interrupt
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  logic k32_c;
  logic k64_c;
  assign k32_c = req_valid_i & kern_c & ~wide_kernel_addressing_i &
                 (vaddr_i[63:32] == {32{vaddr_i[31]}});
  assign k64_c = req_valid_i & kern_c & wide_kernel_addressing_i;

  direct_pa_a:
    assert property (k32_c && vaddr_i[31:29] == 3'b101 |=>
      paddr_o == PA_W'($past(vaddr_i[31:0]) - `KSD_DIRECT_BASE) && !mapped_o)
    else $error("direct window physical address wrong");
  direct_nocache_a:
    assert property (k32_c && vaddr_i[31:29] == 3'b101 |=>
      uncached_o && seg_o == ksd_pkg::seg_direct_uncached)
    else $error("direct window not uncached");
  sup32_mapped_a:
    assert property (k32_c && vaddr_i[31:29] == 3'b110 |=>
      mapped_o && seg_o == ksd_pkg::seg_sup32 && !uncached_o)
    else $error("supervisor window not mapped");
  high32_mapped_a:
    assert property (k32_c && vaddr_i[31:29] == 3'b111 && vaddr_i[31:22] != 10'h3fc |=>
      mapped_o && seg_o == ksd_pkg::seg_mapped_high_kernel)
    else $error("high kernel window not mapped");
  key_space_a:
    assert property (req_valid_i && dif.mapped |=>
      key_space_o == $past(space_identifier_i) && key_vaddr_o == $past(vaddr_i))
    else $error("lookup key lacks space identifier");
  rsvd32_a:
    assert property (k32_c && vaddr_i[31:22] == 10'h3fc |=>
      reserved_o && !mapped_o && addr_err_o == $past(rsvd_fault_q))
    else $error("32-bit reserved range not excluded");
  wide_user_a:
    assert property (k64_c && !error_level_flag_i && vaddr_i[63:40] == 24'h0 |=>
      seg_o == ksd_pkg::seg_wide_user && mapped_o)
    else $error("wide user window wrong");
  wide_sup_a:
    assert property (k64_c && vaddr_i[63:40] == 24'h40_0000 |=>
      seg_o == ksd_pkg::seg_wide_sup && !addr_err_o)
    else $error("wide supervisor window wrong");
  wide_phys_a:
    assert property (k64_c && vaddr_i[63:62] == 2'b10 |=>
      seg_o == ksd_pkg::seg_wide_phys && !mapped_o && paddr_o == $past(vaddr_i[35:0]))
    else $error("wide physical window wrong");
  wide_kern_a:
    assert property (k64_c && vaddr_i[63:40] == 24'hc0_0000 && vaddr_i[39:31] != 9'h1ff |=>
      seg_o == ksd_pkg::seg_wide_kernel && mapped_o)
    else $error("wide kernel window wrong");
  compat_a:
    assert property (k64_c && vaddr_i[63:31] == 33'h1_ffff_ffff && vaddr_i[30:29] == 2'b01 |=>
      seg_o == ksd_pkg::seg_compat_uncached_direct && uncached_o)
    else $error("compat uncached window wrong");
  rsvd64_a:
    assert property (k64_c && vaddr_i[63:22] == 42'h3ff_ffff_fffc |=>
      reserved_o && seg_o == ksd_pkg::seg_reserved)
    else $error("64-bit reserved range not excluded");
  erl_user_a:
    assert property (k32_c && error_level_flag_i && !vaddr_i[31] |=>
      uncached_o && !mapped_o && paddr_o == PA_W'($past(vaddr_i[31:0])))
    else $error("error level user region not direct");
  not_kernel_a:
    assert property (req_valid_i && !kern_c |=> seg_o == ksd_pkg::seg_none && !addr_err_o)
    else $error("decode outside kernel mode");
  irq_level_a:
    assert property (req_valid_i && dif.addr_err && mask_q[0] |=> irq_o)
    else $error("address error interrupt missing");
  status_set_a:
    assert property (req_valid_i && dif.addr_err |=> status_q[`KSD_ST_ADDR_ERR])
    else $error("address error not recorded");
  phys_range_a:
    assert property (k64_c && vaddr_i[63:62] == 2'b10 && vaddr_i[58:36] != 23'h0 |=>
      addr_err_o && seg_o == ksd_pkg::seg_wide_phys)
    else $error("wide physical range error missing");

endmodule // ksd_top

// ---- core/ksd_consts.svh ----
// constants for the kernel segment decoder: offsets, fields, reset values, address patterns
// ===========================================================================
`ifndef KSD_CONSTS_SVH
`define KSD_CONSTS_SVH

// ===========================================================================
// address patterns
`define KSD_KMODE 2'h0
`define KSD_DIRECT_BASE 32'ha000_0000
`define KSD_RSVD_TOP10 10'h3fc
`define KSD_WIDE_ZERO22 22'h00_0000
`define KSD_XKSEG_TOP9 9'h1ff
`define KSD_COMPAT_ONES 31'h7fff_ffff
`define KSD_PHYS_ZERO23 23'h00_0000

// ===========================================================================
// register map
`define KSD_OFS_CTRL 8'h00
`define KSD_OFS_STATUS 8'h04
`define KSD_OFS_MASK 8'h08
`define KSD_OFS_ERR_LO 8'h0c
`define KSD_OFS_ERR_HI 8'h10
`define KSD_ST_ADDR_ERR 0
`define KSD_ST_RSVD 1
`define KSD_ST_ERL_USER 2
`define KSD_CTRL_RSVD_FAULT 0
`define KSD_CTRL_RST 1'h1
`define KSD_MASK_RST 3'h0
`define KSD_RESP_OKAY 2'h0
`define KSD_RESP_SLVERR 2'h2

`endif

// ---- core/ksd_pkg.sv ----
// types shared by the kernel segment decoder files
package ksd_pkg;

  // segment classes reported to the translation buffer and cache
  typedef enum logic [3:0] {
    seg_none = 4'h0,
    seg_user = 4'h1,
    seg_other = 4'h2,
    seg_direct_uncached = 4'h3,
    seg_sup32 = 4'h4,
    seg_mapped_high_kernel = 4'h5,
    seg_reserved = 4'h6,
    seg_wide_user = 4'h7,
    seg_wide_sup = 4'h8,
    seg_wide_phys = 4'h9,
    seg_wide_kernel = 4'ha,
    seg_compat_cached_direct = 4'hb,
    seg_compat_uncached_direct = 4'hc,
    seg_compat_sup = 4'hd,
    seg_compat_high_kernel = 4'he
  } ksd_seg_t;

endpackage

// ---- core/ksd_dec_if.sv ----
// interface between the decoder top and its combinational classifier
`timescale 1ns/10ps
interface ksd_dec_if #(
  parameter int PA_W = 36
);
  logic [63:0] vaddr;
  logic kernel;
  logic wide;
  logic error_level_flag;
  logic rsvd_fault;
  ksd_pkg::ksd_seg_t seg;
  logic mapped;
  logic uncached;
  logic [PA_W-1:0] paddr;
  logic reserved;
  logic addr_err;
  logic erl_user;

  modport dec (input vaddr, kernel, wide, error_level_flag, rsvd_fault,
               output seg, mapped, uncached, paddr, reserved, addr_err, erl_user);
  modport use_side (output vaddr, kernel, wide, error_level_flag, rsvd_fault,
                    input seg, mapped, uncached, paddr, reserved, addr_err, erl_user);
endinterface // ksd_dec_if

// ---- core/ksd_classify.sv ----
// combinational segment classifier for kernel-mode virtual addresses
`timescale 1ns/10ps
`include "ksd_consts.svh"
module ksd_classify #(
  parameter int PA_W = 36
) (
  // request and answer
  ksd_dec_if.dec d
);

  // ===========================================================================
  // decode
  // pure logic so the top can register one clean answer per request
  always_comb begin
    d.seg = ksd_pkg::seg_none;
    d.mapped = 1'b0;
    d.uncached = 1'b0;
    d.paddr = '0;
    d.reserved = 1'b0;
    d.addr_err = 1'b0;
    d.erl_user = 1'b0;
    if (d.kernel) begin
      if (!d.wide) begin
        if (d.vaddr[63:32] != {32{d.vaddr[31]}}) begin
          d.addr_err = 1'b1; // bad sign extension
        end else if (!d.vaddr[31]) begin
          d.seg = ksd_pkg::seg_user;
          if (d.error_level_flag) begin
            d.uncached = 1'b1;
            d.erl_user = 1'b1;
            d.paddr = PA_W'(d.vaddr[31:0]);
          end else begin
            d.mapped = 1'b1;
          end
        end else begin
          unique case (d.vaddr[30:29])
            2'b00: d.seg = ksd_pkg::seg_other; // cached direct window decoded elsewhere
            2'b01: begin
              d.seg = ksd_pkg::seg_direct_uncached;
              d.uncached = 1'b1;
              d.paddr = PA_W'(d.vaddr[31:0] - `KSD_DIRECT_BASE);
            end
            2'b10: begin
              d.seg = ksd_pkg::seg_sup32;
              d.mapped = 1'b1;
            end
            2'b11: begin
              if (d.vaddr[31:22] == `KSD_RSVD_TOP10) begin
                d.seg = ksd_pkg::seg_reserved;
                d.reserved = 1'b1;
                d.addr_err = d.rsvd_fault;
              end else begin
                d.seg = ksd_pkg::seg_mapped_high_kernel;
                d.mapped = 1'b1;
              end
            end
          endcase
        end
      end else begin
        unique case (d.vaddr[63:62])
          2'b00: begin
            if (d.error_level_flag && d.vaddr[61:31] == '0) begin
              d.seg = ksd_pkg::seg_user;
              d.uncached = 1'b1;
              d.erl_user = 1'b1;
              d.paddr = PA_W'(d.vaddr[30:0]);
            end else if (d.vaddr[61:40] == `KSD_WIDE_ZERO22) begin
              d.seg = ksd_pkg::seg_wide_user;
              d.mapped = 1'b1;
            end else begin
              d.addr_err = 1'b1;
            end
          end
          2'b01: begin
            if (d.vaddr[61:40] == `KSD_WIDE_ZERO22) begin
              d.seg = ksd_pkg::seg_wide_sup;
              d.mapped = 1'b1;
            end else begin
              d.addr_err = 1'b1;
            end
          end
          2'b10: begin
            d.seg = ksd_pkg::seg_wide_phys;
            d.paddr = PA_W'(d.vaddr[35:0]);
            d.addr_err = (d.vaddr[58:36] != `KSD_PHYS_ZERO23);
          end
          2'b11: begin
            if (d.vaddr[61:31] == `KSD_COMPAT_ONES) begin
              unique case (d.vaddr[30:29])
                2'b00: begin
                  d.seg = ksd_pkg::seg_compat_cached_direct;
                  d.paddr = PA_W'(d.vaddr[28:0]);
                end
                2'b01: begin
                  d.seg = ksd_pkg::seg_compat_uncached_direct;
                  d.uncached = 1'b1;
                  d.paddr = PA_W'(d.vaddr[28:0]);
                end
                2'b10: begin
                  d.seg = ksd_pkg::seg_compat_sup;
                  d.mapped = 1'b1;
                end
                2'b11: begin
                  if (d.vaddr[31:22] == `KSD_RSVD_TOP10) begin
                    d.seg = ksd_pkg::seg_reserved;
                    d.reserved = 1'b1;
                    d.addr_err = d.rsvd_fault;
                  end else begin
                    d.seg = ksd_pkg::seg_compat_high_kernel;
                    d.mapped = 1'b1;
                  end
                end
              endcase
            end else if (d.vaddr[61:40] == `KSD_WIDE_ZERO22 &&
                         d.vaddr[39:31] != `KSD_XKSEG_TOP9) begin
              d.seg = ksd_pkg::seg_wide_kernel;
              d.mapped = 1'b1;
            end else begin
              d.addr_err = 1'b1;
            end
          end
        endcase
      end
    end
  end

endmodule // ksd_classify

// ---- tb/ksd_pipe_model.sv ----
// pipeline-side model that issues access requests to the decoder
`timescale 1ns/10ps
module ksd_pipe_model (
  // clock
  input wire logic clock_i,
  // request towards the decoder
  output logic req_valid_o,
  output logic [63:0] vaddr_o,
  output logic [7:0] space_o,
  output logic [1:0] mode_o,
  output logic exl_o,
  output logic erl_o,
  output logic wide_o
);
  // ======
  // quiet bus at time zero
  initial begin
    req_valid_o = 1'h0;
    vaddr_o = 64'h0;
    {space_o, mode_o, exl_o, erl_o, wide_o} = 13'h0;
  end
  // one request per call, launched after an edge and held to the next one
  task automatic send(input logic [63:0] v, input logic [12:0] ctl);
    req_valid_o <= 1'h1;
    vaddr_o <= v;
    {space_o, mode_o, exl_o, erl_o, wide_o} <= ctl;
    @(posedge clock_i);
  endtask
  // idle scrambles the address so nothing can lean on a stale value
  task automatic idle();
    req_valid_o <= 1'h0;
    vaddr_o <= ~vaddr_o;
    @(posedge clock_i);
  endtask
endmodule // ksd_pipe_model

// ---- tb/kernel_segment_decoder_tb_top.sv ----
// self-checking testbench for the kernel segment decoder
`timescale 1ns/10ps
module kernel_segment_decoder_tb_top;
  // ======
  // stimulus and observed signals
  logic clock_i = 1'h0;
  logic srst_i = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic req_valid_i, exception_level_flag_i, error_level_flag_i, wide_kernel_addressing_i;
  logic [63:0] vaddr_i, key_vaddr_o, pva;
  logic [7:0] space_identifier_i, key_space_o;
  logic [1:0] privilege_mode_field_i, s_axi_bresp, s_axi_rresp;
  logic dec_valid_o, mapped_o, uncached_o, reserved_o, addr_err_o, irq_o;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  logic [35:0] paddr_o;
  ksd_pkg::ksd_seg_t seg_o, es;
  int num_errors = 0, checked = 0, cyc = 0;
  logic pv = 1'h0, rf = 1'h1, kn, eu, em, ee;
  logic [12:0] pc;

  ksd_top u_ksd_top (.clock_i, .srst_i, .req_valid_i, .vaddr_i, .space_identifier_i,
    .privilege_mode_field_i, .exception_level_flag_i, .error_level_flag_i,
    .wide_kernel_addressing_i, .dec_valid_o, .seg_o, .mapped_o, .uncached_o, .paddr_o,
    .key_space_o, .key_vaddr_o, .reserved_o, .addr_err_o, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_o);
  ksd_pipe_model u_ksd_pipe_model (.clock_i, .req_valid_o(req_valid_i), .vaddr_o(vaddr_i),
    .space_o(space_identifier_i), .mode_o(privilege_mode_field_i),
    .exl_o(exception_level_flag_i), .erl_o(error_level_flag_i),
    .wide_o(wide_kernel_addressing_i));

  // ======
  // clock and a cycle ceiling so a hung handshake still ends the run
  initial forever #4 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] ex);
    checked++;
    if (got !== ex) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ======
  // axi4-lite master: hold each channel until its own ready edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge clock_i);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge clock_i);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask

  // ======
  // expected segment class of a kernel access
  function automatic ksd_pkg::ksd_seg_t eseg(input logic [63:0] v, input logic w);
    if (!w && v[63:32] != {32{v[31]}}) return ksd_pkg::seg_none;
    if (!w && !v[31]) return ksd_pkg::seg_user;
    if (!w && v[31:29] == 3'h4) return ksd_pkg::seg_other;
    if (!w && v[31:29] == 3'h5) return ksd_pkg::seg_direct_uncached;
    if (!w && v[31:29] == 3'h6) return ksd_pkg::seg_sup32;
    if (!w) return v[31:22] == 10'h3fc ? ksd_pkg::seg_reserved
                                        : ksd_pkg::seg_mapped_high_kernel;
    if (v[63:62] == 2'h0) return v[61:40] == 22'h0 ? ksd_pkg::seg_wide_user : ksd_pkg::seg_none;
    if (v[63:62] == 2'h1) return v[61:40] == 22'h0 ? ksd_pkg::seg_wide_sup : ksd_pkg::seg_none;
    if (v[63:62] == 2'h2) return ksd_pkg::seg_wide_phys;
    if (v[61:31] != 31'h7fff_ffff) return (v[61:40] == 22'h0 && v[39:31] != 9'h1ff)
                                          ? ksd_pkg::seg_wide_kernel : ksd_pkg::seg_none;
    if (v[30:29] == 2'h0) return ksd_pkg::seg_compat_cached_direct;
    if (v[30:29] == 2'h1) return ksd_pkg::seg_compat_uncached_direct;
    if (v[30:29] == 2'h2) return ksd_pkg::seg_compat_sup;
    return v[30:22] == 9'h1fc ? ksd_pkg::seg_reserved : ksd_pkg::seg_compat_high_kernel;
  endfunction

  // expected physical address of the unmapped windows, zero elsewhere
  function automatic logic [35:0] epa(input logic [63:0] v, input ksd_pkg::ksd_seg_t s);
    if (s == ksd_pkg::seg_wide_phys) return v[35:0];
    if (s inside {ksd_pkg::seg_direct_uncached, ksd_pkg::seg_compat_cached_direct,
                  ksd_pkg::seg_compat_uncached_direct}) return {7'h0, v[28:0]};
    return 36'h0;
  endfunction

  // ======
  // answer checker: remember each request, judge its answer half a cycle later
  always @(posedge clock_i) begin
    pv <= req_valid_i & ~srst_i;
    pva <= vaddr_i;
    pc <= {space_identifier_i, privilege_mode_field_i, exception_level_flag_i,
           error_level_flag_i, wide_kernel_addressing_i};
  end
  always @(negedge clock_i) if (!srst_i) begin
    kn = pc[4:3] == 2'h0 || pc[2] || pc[1];
    es = kn ? eseg(pva, pc[0]) : ksd_pkg::seg_none;
    eu = kn && pc[1] && (pc[0] ? pva[63:31] == 33'h0 : es == ksd_pkg::seg_user);
    ee = kn && !eu && (es == ksd_pkg::seg_none || (es == ksd_pkg::seg_reserved && rf) ||
      (es == ksd_pkg::seg_wide_phys && pva[58:36] != 23'h0));
    em = !eu && es inside {ksd_pkg::seg_sup32, ksd_pkg::seg_mapped_high_kernel,
      ksd_pkg::seg_wide_user, ksd_pkg::seg_wide_sup, ksd_pkg::seg_wide_kernel,
      ksd_pkg::seg_compat_sup, ksd_pkg::seg_compat_high_kernel, ksd_pkg::seg_user};
    // the error-level user region always reports as the plain user class
    if (eu) es = ksd_pkg::seg_user;
    chk(dec_valid_o, pv);
    if (pv) begin
      chk(seg_o, es);
      chk(mapped_o, em);
      chk(uncached_o, eu || es inside {ksd_pkg::seg_direct_uncached,
        ksd_pkg::seg_compat_uncached_direct});
      chk(paddr_o, eu ? pva[35:0] : epa(pva, es));
      chk(key_space_o, em ? pc[12:5] : 8'h0);
      chk(key_vaddr_o, pva);
      chk(reserved_o, es == ksd_pkg::seg_reserved);
      chk(addr_err_o, ee);
    end
  end

  // ======
  // main sequence
  initial begin
    logic [63:0] bases [14] = '{64'hffff_ffff_a000_0000, 64'hffff_ffff_c000_0000,
      64'hffff_ffff_e000_0000, 64'hffff_ffff_ff00_0000, 64'h0000_00ff_ffff_fff8,
      64'h4000_00ff_ffff_fff8, 64'h8000_000f_ffff_fff8, 64'hc000_00ff_7fff_fff8,
      64'hc000_00ff_8000_0000, 64'hffff_ffff_8000_0000, 64'hffff_ffff_a000_0000,
      64'hffff_ffff_c000_0000, 64'hffff_ffff_e000_0000, 64'hffff_ffff_ff00_0000};
    logic [3:0] modes [4] = '{4'h0, 4'ha, 4'h9, 4'h8};
    int k;
    void'($urandom(84587));
    repeat (20) @(posedge clock_i);
    srst_i <= 1'h0;
    // reset values, then an unmapped offset both ways
    axr(8'h00, 32'h1, 2'h0);
    axr(8'h04, 32'h0, 2'h0);
    axr(8'h08, 32'h0, 2'h0);
    axr(8'h14, 32'h0, 2'h2);
    axw(8'h14, 32'hff, 2'h2);
    // address error while masked, then unmask, then clear by writing one
    u_ksd_pipe_model.send(64'hc000_0100_0000_0000, {8'h5a, 5'h01});
    u_ksd_pipe_model.idle();
    @(negedge clock_i);
    chk(irq_o, 1'h0);
    axr(8'h04, 32'h1, 2'h0);
    axr(8'h0c, 32'h0, 2'h0);
    axr(8'h10, 32'hc000_0100, 2'h0);
    axw(8'h08, 32'h1, 2'h0);
    @(negedge clock_i);
    chk(irq_o, 1'h1);
    axw(8'h04, 32'h1, 2'h0);
    @(negedge clock_i);
    chk(irq_o, 1'h0);
    // reserved hit with the fault disabled, back to back with an error-level user access
    axw(8'h00, 32'h0, 2'h0);
    rf = 1'h0;
    u_ksd_pipe_model.send(64'hffff_ffff_ff00_0040, {8'h11, 5'h00});
    u_ksd_pipe_model.send(64'h0000_0000_0000_1000, {8'h22, 5'h12});
    u_ksd_pipe_model.idle();
    axr(8'h04, 32'h6, 2'h0);
    axw(8'h00, 32'h1, 2'h0);
    rf = 1'h1;
    // out-of-range addresses in both widths, then the wide error-level user region
    u_ksd_pipe_model.send(64'h8000_1000_0000_0040, {8'h3c, 5'h01});
    u_ksd_pipe_model.send(64'h0000_0100_0000_0000, {8'h3c, 5'h01});
    u_ksd_pipe_model.send(64'h0000_0001_a000_0000, {8'h3c, 5'h00});
    u_ksd_pipe_model.send(64'h0000_0000_7fff_0000, {8'h3c, 5'h03});
    // every window boundary except the 32-bit user and cached direct ones, then random traffic every cycle in kernel, exl, erl and user settings
    for (k = 0; k < 14; k++) u_ksd_pipe_model.send(bases[k], {8'h3c, 4'h0, k > 3});
    repeat (400) begin
      k = $urandom % 14;
      u_ksd_pipe_model.send(bases[k] | ($urandom & 32'h0fff_fff8),
                            {8'($urandom), modes[$urandom % 4], k > 3});
    end
    u_ksd_pipe_model.idle();
    @(negedge clock_i);
    summarize();
  end
endmodule // kernel_segment_decoder_tb_top
